// ---- rtl/psir_latch_high.sv ----
/*
 * Latch-high status flag: an event sets it, a read of the status word
 * clears it; a new event in the clearing cycle keeps it set.
 * Assumes one clock, an asynchronous active-low reset and a clock
 * enable that freezes the flag while low.
 */
`timescale 1ns/1ps
module psir_latch_high (
   input wire logic clk, // management clock
   input wire logic nrst, // async reset, active low
   input wire logic ce, // clock enable
   input wire logic set_evt, // event level, sets the flag
   input wire logic clr, // status read, clears the flag
   output logic flag // latched flag
);

   logic flag_reg;
   logic flag_next;

   // set wins so an event in the read cycle is not lost
   assign flag_next = set_evt | (flag_reg & ~clr);
   assign flag = flag_reg;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         flag_reg <= 1'b0;
      end else if (ce) begin
         flag_reg <= flag_next;
      end
   end

endmodule

// ---- rtl/psir_latch_low.sv ----
/*
 * Latch-low link flag: any link failure clears it, and it returns to
 * one only on a status read while the link is good.
 * Assumes one clock, an asynchronous active-low reset and a clock
 * enable that freezes the flag while low.
 */
`timescale 1ns/1ps
module psir_latch_low (
   input wire logic clk, // management clock
   input wire logic nrst, // async reset, active low
   input wire logic ce, // clock enable
   input wire logic good, // link good level
   input wire logic rd, // status read, refreshes the flag
   output logic flag // latched link flag
);

   logic flag_reg;
   logic flag_next;

   // failure wins over the refresh by the read
   assign flag_next = good & (flag_reg | rd);
   assign flag = flag_reg;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         flag_reg <= 1'b0;
      end else if (ce) begin
         flag_reg <= flag_next;
      end
   end

endmodule

// ---- rtl/psir_pkg.sv ----
/*
 * Constants of the transceiver status and identifier register logic:
 * register offsets, field positions, fixed capability values, reset
 * values and the default identity fields.
 * Assumes it is compiled before every other file of the block.
 */
package psir_pkg;

   // ****************************************************
   // register offsets on the management port
   // ****************************************************
   localparam logic [4:0] ADDR_STATUS = 5'h01;
   localparam logic [4:0] ADDR_ID1 = 5'h02;
   localparam logic [4:0] ADDR_ID2 = 5'h03;

   // ****************************************************
   // status word field positions
   // ****************************************************
   localparam int unsigned BIT_T4 = 15;
   localparam int unsigned BIT_TX_FD = 14;
   localparam int unsigned BIT_TX_HD = 13;
   localparam int unsigned BIT_10_FD = 12;
   localparam int unsigned BIT_10_HD = 11;
   localparam int unsigned RSV_HI = 10;
   localparam int unsigned RSV_LO = 8;
   localparam int unsigned BIT_UNIDIR = 7;
   localparam int unsigned BIT_NO_PRE = 6;
   localparam int unsigned BIT_AN_DONE = 5;
   localparam int unsigned BIT_RFAULT = 4;
   localparam int unsigned BIT_AN_ABLE = 3;
   localparam int unsigned BIT_LINK = 2;
   localparam int unsigned BIT_JABBER = 1;
   localparam int unsigned BIT_EXT = 0;

   // ****************************************************
   // fixed status values
   // ****************************************************
   localparam logic CAP_T4 = 1'b0;
   localparam logic [3:0] CAP_SPEEDS = 4'hf;
   localparam logic [2:0] RSV_VAL = 3'h0;
   localparam logic CAP_UNIDIR = 1'b1;
   localparam logic CAP_NO_PRE = 1'b1;
   localparam logic CAP_AN_ABLE = 1'b1;
   localparam logic CAP_EXT = 1'b1;

   // ****************************************************
   // reset values
   // ****************************************************
   localparam logic RST_AN_DONE = 1'b0;
   localparam logic RST_RFAULT = 1'b0;
   localparam logic RST_LINK = 1'b0;
   localparam logic RST_JABBER = 1'b0;
   localparam logic RST_PRE_NEEDED = 1'b1;
   localparam logic [15:0] RST_RDATA = 16'h0000;
   localparam logic [4:0] RST_ADDR = 5'h00;

   // ****************************************************
   // identifier word two field positions
   // ****************************************************
   localparam int unsigned ID2_OUI_LSB = 10;
   localparam int unsigned ID2_MODEL_LSB = 4;
   localparam int unsigned ID2_REV_LSB = 0;

   // arbitrary neutral identity values, not a real maker's code
   localparam logic [0:23] VENDOR_CODE_DEF = 24'h5a3c69;
   localparam logic [5:0] MODEL_DEF = 6'h2a;
   localparam logic [3:0] REV_DEF = 4'h3;

endpackage

// ---- rtl/psir_regs.sv ----
/*
 * Status word and identifier words of an Ethernet transceiver's
 * management register set, with latch-high fault and jabber flags,
 * a latch-low link flag and the preamble-needed tracker.
 * Assumes a serial management framer in front of it that turns each
 * valid frame into a one-cycle read or write strobe with an address,
 * and reports bad opcodes or turnarounds as a one-cycle pulse.
 */
// How it works
// - Top bit 0, bits 14..11 all ones
// - Bits 10..8 read zero, writes ignored
// - Bit 7 fixed one: unidirectional transmit
// - Bit 6 one; preamble needed after reset or a frame error
// - Negotiation-done flag mirrors progress, resets zero
// - Remote fault latches high until read
// - Bit 3 fixed one: negotiation ability
// - Link flag latches low, refreshed by read
// - Jabber latches high until read, 10 Mb only
// - Bit 0 fixed one: extended registers
// - Both identifier words form 32-bit identity
// - Word one holds vendor bits 3..18
// - Identity may read all zeros
// - Word two: vendor bits, model, revision
`timescale 1ns/1ps
module psir_regs #(
   parameter logic [0:23] VENDOR_CODE = psir_pkg::VENDOR_CODE_DEF,
   parameter logic [5:0] MODEL = psir_pkg::MODEL_DEF,
   parameter logic [3:0] REV = psir_pkg::REV_DEF,
   parameter logic ID_ZERO = 1'b0
) (
   input wire logic CLK, // management clock, 200 MHz
   input wire logic NRST, // async reset, active low
   input wire logic CE, // clock enable, freezes all state
   input wire logic [4:0] MGMT_ADDR, // register address
   input wire logic MGMT_RD, // read strobe, one cycle
   input wire logic MGMT_WR, // write strobe, one cycle
   input wire logic [15:0] MGMT_WDATA, // write data, discarded
   input wire logic FRAME_ERROR, // bad opcode or turnaround
   input wire logic AN_COMPLETE, // negotiation finished level
   input wire logic FAR_END_FAULT, // far-end fault indication
   input wire logic PARTNER_FAULT, // remote fault from partner
   input wire logic LINK_GOOD, // good link at 10 or 100 Mb/s
   input wire logic JABBER_SEEN, // jabber condition level
   input wire logic SPEED_10, // link runs at 10 Mb/s
   output logic [15:0] MGMT_RDATA, // read data, registered
   output logic MGMT_RVALID, // read data valid pulse
   output logic PREAMBLE_NEEDED // next frame must carry preamble
);

   // ****************************************************
   // decode
   // ****************************************************
   logic rd_go;
   logic wr_go;
   logic hit_status;
   logic hit_id1;
   logic hit_id2;
   logic rd_status;

   assign rd_go = CE & MGMT_RD;
   // a read and a write never come together; read takes priority
   assign wr_go = CE & MGMT_WR & ~MGMT_RD;
   assign hit_status = (MGMT_ADDR == psir_pkg::ADDR_STATUS);
   assign hit_id1 = (MGMT_ADDR == psir_pkg::ADDR_ID1);
   assign hit_id2 = (MGMT_ADDR == psir_pkg::ADDR_ID2);
   // only reads touch flags; a write only clears the preamble need
   assign rd_status = MGMT_RD & hit_status;

   // ****************************************************
   // latched status flags
   // ****************************************************
   logic rfault_evt;
   logic jabber_evt;
   logic rfault_flag;
   logic jabber_flag;
   logic link_flag;

   assign rfault_evt = FAR_END_FAULT | PARTNER_FAULT;
   // jabber has no meaning at 100 Mb/s, so it is not recorded there
   assign jabber_evt = JABBER_SEEN & SPEED_10;

   psir_latch_high u_rfault (
      .clk(CLK),
      .nrst(NRST),
      .ce(CE),
      .set_evt(rfault_evt),
      .clr(rd_status),
      .flag(rfault_flag)
   );

   psir_latch_high u_jabber (
      .clk(CLK),
      .nrst(NRST),
      .ce(CE),
      .set_evt(jabber_evt),
      .clr(rd_status),
      .flag(jabber_flag)
   );

   psir_latch_low u_link (
      .clk(CLK),
      .nrst(NRST),
      .ce(CE),
      .good(LINK_GOOD),
      .rd(rd_status),
      .flag(link_flag)
   );

   // ****************************************************
   // negotiation done and preamble tracking
   // ****************************************************
   logic an_done_reg;
   logic pre_needed_reg;
   logic pre_needed_next;

   // framer error re-arms the preamble; set wins over a same-cycle frame
   assign pre_needed_next = FRAME_ERROR |
      (pre_needed_reg & ~(MGMT_RD | MGMT_WR));

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         an_done_reg <= psir_pkg::RST_AN_DONE;
         pre_needed_reg <= psir_pkg::RST_PRE_NEEDED;
      end else if (CE) begin
         an_done_reg <= AN_COMPLETE;
         pre_needed_reg <= pre_needed_next;
      end
   end

   // ****************************************************
   // register words
   // ****************************************************
   logic [15:0] status_word;
   logic [15:0] id1_word;
   logic [15:0] id2_word;

   assign status_word[psir_pkg::BIT_T4] = psir_pkg::CAP_T4;
   assign status_word[psir_pkg::BIT_TX_FD:psir_pkg::BIT_10_HD] =
      psir_pkg::CAP_SPEEDS;
   assign status_word[psir_pkg::RSV_HI:psir_pkg::RSV_LO] =
      psir_pkg::RSV_VAL;
   assign status_word[psir_pkg::BIT_UNIDIR] = psir_pkg::CAP_UNIDIR;
   assign status_word[psir_pkg::BIT_NO_PRE] = psir_pkg::CAP_NO_PRE;
   assign status_word[psir_pkg::BIT_AN_DONE] = an_done_reg;
   assign status_word[psir_pkg::BIT_RFAULT] = rfault_flag;
   assign status_word[psir_pkg::BIT_AN_ABLE] = psir_pkg::CAP_AN_ABLE;
   assign status_word[psir_pkg::BIT_LINK] = link_flag;
   assign status_word[psir_pkg::BIT_JABBER] = jabber_flag;
   assign status_word[psir_pkg::BIT_EXT] = psir_pkg::CAP_EXT;

   // vendor bit 1 sits at VENDOR_CODE[0]; the top two are never stored
   assign id1_word = ID_ZERO ? 16'h0000 : VENDOR_CODE[2:17];
   assign id2_word = ID_ZERO ? 16'h0000 :
      {VENDOR_CODE[18:23], MODEL, REV};

   // ****************************************************
   // read port
   // ****************************************************
   logic [15:0] rdata_reg;
   logic [15:0] rdata_next;
   logic rvalid_reg;
   logic [4:0] rd_addr_reg;

   // unmapped addresses read as zero
   assign rdata_next = hit_status ? status_word :
      hit_id1 ? id1_word :
      hit_id2 ? id2_word : 16'h0000;

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         rdata_reg <= psir_pkg::RST_RDATA;
         rvalid_reg <= 1'b0;
         rd_addr_reg <= psir_pkg::RST_ADDR;
      end else if (CE) begin
         rvalid_reg <= MGMT_RD;
         if (MGMT_RD) begin
            rdata_reg <= rdata_next;
            rd_addr_reg <= MGMT_ADDR;
         end
      end
   end

   assign MGMT_RDATA = rdata_reg;
   assign MGMT_RVALID = rvalid_reg;
   assign PREAMBLE_NEEDED = pre_needed_reg;

   // ****************************************************
   // assertions
   // ****************************************************
   logic rd_stat_done;

   assign rd_stat_done = MGMT_RVALID && rd_addr_reg == psir_pkg::ADDR_STATUS;

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!NRST);

   AST_CAPS: assert property (
      rd_stat_done |-> MGMT_RDATA[15:11] == 5'h0f)
      else $error("capability bits wrong");
   AST_RSV: assert property (
      rd_stat_done |-> MGMT_RDATA[10:8] == 3'h0)
      else $error("reserved status bits not zero");
   AST_UNIDIR: assert property (
      rd_stat_done |-> MGMT_RDATA[7])
      else $error("unidirectional bit not set");
   AST_NOPRE: assert property (
      rd_stat_done |-> MGMT_RDATA[6] && MGMT_RDATA[3] && MGMT_RDATA[0])
      else $error("fixed ability bits not set");
   AST_PRE_REARM: assert property (
      CE && FRAME_ERROR |=> PREAMBLE_NEEDED)
      else $error("preamble not re-armed after frame error");
   AST_PRE_DROP: assert property (
      CE && MGMT_RD && !FRAME_ERROR |=> !PREAMBLE_NEEDED)
      else $error("preamble still needed after a frame");
   AST_AN: assert property (
      rd_go && hit_status |=> MGMT_RDATA[5] == $past(an_done_reg))
      else $error("negotiation flag not reported");
   AST_RF_HOLD: assert property (
      rfault_flag && CE && !rd_status |=> rfault_flag)
      else $error("remote fault dropped without read");
   AST_RF_CLR: assert property (
      rd_go && hit_status && !rfault_evt |=> !rfault_flag)
      else $error("remote fault not cleared by read");
   AST_LINK_FAIL: assert property (
      CE && !LINK_GOOD |=> !link_flag ##1 (!link_flag || $past(rd_status)))
      else $error("link flag rose without a read");
   AST_LINK_UP: assert property (
      rd_go && hit_status && LINK_GOOD |=> link_flag)
      else $error("link flag not refreshed by read");
   AST_JAB: assert property (
      CE && JABBER_SEEN && SPEED_10
      |=> jabber_flag && MGMT_RVALID == $past(MGMT_RD))
      else $error("jabber not latched");
   AST_ID1: assert property (
      MGMT_RVALID && rd_addr_reg == psir_pkg::ADDR_ID1
      |-> MGMT_RDATA == (ID_ZERO ? 16'h0000 : VENDOR_CODE[2:17]))
      else $error("identifier word one wrong");
   AST_WR_NOCLR: assert property (
      wr_go && rfault_flag |=> rfault_flag && !MGMT_RVALID)
      else $error("write disturbed status");
   AST_FREEZE: assert property (
      !CE |=> $stable(MGMT_RDATA) && $stable(MGMT_RVALID))
      else $error("state moved while clock enable low");

   // ****************************************************
   // assertions on the latched flags
   // ****************************************************
   AST_RF_SET: assert property (
      CE && rfault_evt |=> rfault_flag)
      else $error("remote fault not latched");
   AST_RF_NOSET: assert property (
      CE && !rfault_flag && !rfault_evt |=> !rfault_flag)
      else $error("remote fault set without event");
   AST_JAB_HOLD: assert property (
      jabber_flag && CE && !rd_status |=> jabber_flag)
      else $error("jabber dropped without read");
   AST_JAB_CLR: assert property (
      rd_go && hit_status && !jabber_evt |=> !jabber_flag)
      else $error("jabber not cleared by read");
   AST_JAB_100: assert property (
      CE && !jabber_flag && !SPEED_10 |=> !jabber_flag)
      else $error("jabber latched outside 10 Mb/s");
   AST_LINK_HOLD: assert property (
      CE && link_flag && LINK_GOOD |=> link_flag)
      else $error("link flag dropped on good link");
   AST_LINK_NORISE: assert property (
      CE && !link_flag && !rd_status |=> !link_flag)
      else $error("link flag set without a read");
   AST_AN_TRACK: assert property (
      CE |=> an_done_reg == $past(AN_COMPLETE))
      else $error("negotiation flag lags its input");

   // ****************************************************
   // assertions on the read port and writes
   // ****************************************************
   AST_RVALID_PULSE: assert property (
      CE && !MGMT_RD |=> !MGMT_RVALID)
      else $error("read valid longer than one cycle");
   AST_ID2: assert property (
      MGMT_RVALID && rd_addr_reg == psir_pkg::ADDR_ID2
      |-> MGMT_RDATA == (ID_ZERO ? 16'h0000 :
      {VENDOR_CODE[18:23], MODEL, REV}))
      else $error("identifier word two wrong");
   AST_ID_ZERO: assert property (
      ID_ZERO && MGMT_RVALID && rd_addr_reg != psir_pkg::ADDR_STATUS
      |-> MGMT_RDATA == 16'h0000)
      else $error("identity not all zero");
   AST_UNMAPPED: assert property (
      MGMT_RVALID && rd_addr_reg != psir_pkg::ADDR_STATUS &&
      rd_addr_reg != psir_pkg::ADDR_ID1 &&
      rd_addr_reg != psir_pkg::ADDR_ID2 |-> MGMT_RDATA == 16'h0000)
      else $error("unmapped address not read as zero");
   AST_PRE_WR: assert property (
      CE && MGMT_WR && !FRAME_ERROR |=> !PREAMBLE_NEEDED)
      else $error("preamble still needed after a write");
   AST_PRE_KEEP: assert property (
      CE && PREAMBLE_NEEDED && !MGMT_RD && !MGMT_WR |=> PREAMBLE_NEEDED)
      else $error("preamble need lost without a frame");
   AST_WR_KEEP: assert property (
      wr_go |=> $stable(MGMT_RDATA))
      else $error("write changed read data");
   AST_FREEZE_FLAGS: assert property (
      !CE |=> $stable(rfault_flag) && $stable(jabber_flag) &&
      $stable(link_flag) && $stable(an_done_reg) && $stable(PREAMBLE_NEEDED))
      else $error("flag moved while clock enable low");

endmodule

// ---- test/psir_host.sv ----
/*
 * Behavioural station management host: issues register reads and
 * writes as one-cycle strobes, and sends a preamble when one is due.
 * Assumes the bench calls its tasks at a falling clock edge.
 */
`timescale 1ns/1ps
module psir_host (
   input wire logic clk, // management clock
   input wire logic nrst, // async reset, active low
   output logic [4:0] addr, // register address
   output logic rd, // read strobe
   output logic wr, // write strobe
   output logic [15:0] wdata, // write data
   output logic frame_error, // bad frame pulse
   input wire logic [15:0] rdata, // read data
   input wire logic rvalid // read data valid
);
   logic need_pre = 1'b1;

   initial begin
      addr = 5'h00;
      rd = 1'b0;
      wr = 1'b0;
      wdata = 16'h0000;
      frame_error = 1'b0;
   end

   // a fresh reset means the next frame must carry a preamble
   always @(negedge nrst) need_pre = 1'b1;

   task automatic xfer(input logic is_rd, input logic [4:0] a,
      input logic [15:0] wd, output logic [15:0] d, output logic v);
      if (need_pre) begin
         repeat (32) @(negedge clk);
         need_pre = 1'b0;
      end
      addr = a;
      rd = is_rd;
      wr = !is_rd;
      wdata = wd;
      @(posedge clk);
      @(negedge clk);
      d = rdata;
      v = rvalid;
      rd = 1'b0;
      wr = 1'b0;
      // released lines do not keep the last value
      addr = ~a;
      wdata = ~wd;
      // idle edge so a strobe never falls and rises in one step
      @(negedge clk);
   endtask

   task automatic bad_frame();
      frame_error = 1'b1;
      @(negedge clk);
      frame_error = 1'b0;
      need_pre = 1'b1;
   endtask
endmodule

// ---- test/psir_regs_test.sv ----
/*
 * Self-checking bench of the status and identifier registers.
 * Assumes the host model drives the strobe port; the bench drives
 * the link condition levels at the falling clock edge.
 */
`timescale 1ns/1ps
module psir_regs_test;
   // arbitrary identity values, not a real maker's code
   localparam logic [0:23] VC = 24'hc3a51e;
   localparam logic [5:0] MDL = 6'h15;
   localparam logic [3:0] RV = 4'h9;
   logic clk = 1'b0, nrst = 1'b0, ce = 1'b1, an = 1'b0, fef = 1'b0;
   logic pf = 1'b0, lg = 1'b0, jab = 1'b0, s10 = 1'b0;
   logic [4:0] addr;
   logic rd, wr, fe, rvalid, pre;
   logic [15:0] wdata, rdata, rdata_z, d;
   logic v;
   int errors = 0, checked = 0, cycles = 0;

   always #2.5 clk = ~clk;

   psir_regs #(.VENDOR_CODE(VC), .MODEL(MDL), .REV(RV)) dut (.CLK(clk),
      .NRST(nrst), .CE(ce), .MGMT_ADDR(addr), .MGMT_RD(rd), .MGMT_WR(wr),
      .MGMT_WDATA(wdata), .FRAME_ERROR(fe), .AN_COMPLETE(an),
      .FAR_END_FAULT(fef), .PARTNER_FAULT(pf), .LINK_GOOD(lg),
      .JABBER_SEEN(jab), .SPEED_10(s10), .MGMT_RDATA(rdata),
      .MGMT_RVALID(rvalid), .PREAMBLE_NEEDED(pre));
   // identity switched off: must read zero
   psir_regs #(.ID_ZERO(1'b1)) dut_z (.CLK(clk), .NRST(nrst), .CE(ce),
      .MGMT_ADDR(addr), .MGMT_RD(rd), .MGMT_WR(wr), .MGMT_WDATA(wdata),
      .FRAME_ERROR(fe), .AN_COMPLETE(an), .FAR_END_FAULT(fef),
      .PARTNER_FAULT(pf), .LINK_GOOD(lg), .JABBER_SEEN(jab),
      .SPEED_10(s10), .MGMT_RDATA(rdata_z), .MGMT_RVALID(),
      .PREAMBLE_NEEDED());
   psir_host host (.clk(clk), .nrst(nrst), .addr(addr), .rd(rd), .wr(wr),
      .wdata(wdata), .frame_error(fe), .rdata(rdata), .rvalid(rvalid));

   // ****************************************************
   // checking helpers
   // ****************************************************
   function automatic logic [15:0] st(logic a, f, l, j);
      return {1'b0, 4'hf, 3'h0, 2'b11, a, f, 1'b1, l, j, 1'b1};
   endfunction

   task automatic chk(input logic [15:0] got, exp, input string msg);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
      host.xfer(1'b1, a, 16'h0000, d, v);
      chk({15'h0000, v}, 16'h0001, "read valid");
      chk(d, exp, "read data");
      chk({15'h0000, rvalid}, 16'h0000, "read valid pulse ended");
   endtask

   task automatic finish_test();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         $display("mismatch at %0t: run too long", $time);
         finish_test();
      end
   end

   // ****************************************************
   // scenarios
   // ****************************************************
   task automatic t_reset();
      chk({15'h0000, pre}, 16'h0001, "preamble after reset");
      rd_chk(5'h01, 16'h78c9);
      chk({15'h0000, pre}, 16'h0000, "preamble after frame");
      host.xfer(1'b0, 5'h01, 16'hffff, d, v);
      rd_chk(5'h01, 16'h78c9);
      $display("test reset done");
   endtask

   task automatic t_link();
      lg = 1'b1;
      rd_chk(5'h01, st(0, 0, 0, 0));
      rd_chk(5'h01, st(0, 0, 1, 0));
      lg = 1'b0;
      @(negedge clk);
      lg = 1'b1;
      rd_chk(5'h01, st(0, 0, 0, 0));
      rd_chk(5'h01, st(0, 0, 1, 0));
      $display("test link done");
   endtask

   task automatic t_faults();
      fef = 1'b1;
      @(negedge clk);
      fef = 1'b0;
      host.xfer(1'b0, 5'h01, 16'h0000, d, v);
      rd_chk(5'h02, {VC[2:17]});
      rd_chk(5'h01, st(0, 1, 1, 0));
      rd_chk(5'h01, st(0, 0, 1, 0));
      s10 = 1'b1;
      pf = 1'b1;
      jab = 1'b1;
      @(negedge clk);
      pf = 1'b0;
      jab = 1'b0;
      rd_chk(5'h01, st(0, 1, 1, 1));
      rd_chk(5'h01, st(0, 0, 1, 0));
      s10 = 1'b0;
      jab = 1'b1;
      @(negedge clk);
      jab = 1'b0;
      rd_chk(5'h01, st(0, 0, 1, 0));
      an = 1'b1;
      @(negedge clk);
      rd_chk(5'h01, st(1, 0, 1, 0));
      $display("test faults done");
   endtask

   task automatic t_ident();
      rd_chk(5'h02, VC[2:17]);
      chk(rdata_z, 16'h0000, "zero identity word one");
      rd_chk(5'h03, {VC[18:23], MDL, RV});
      chk(rdata_z, 16'h0000, "zero identity word two");
      rd_chk(5'h1f, 16'h0000);
      host.bad_frame();
      chk({15'h0000, pre}, 16'h0001, "preamble after bad frame");
      rd_chk(5'h01, st(1, 0, 1, 0));
      chk({15'h0000, pre}, 16'h0000, "preamble cleared");
      $display("test ident done");
   endtask

   task automatic t_freeze();
      ce = 1'b0;
      fef = 1'b1;
      lg = 1'b0;
      host.xfer(1'b1, 5'h02, 16'h0000, d, v);
      chk({15'h0000, v}, 16'h0000, "read taken while frozen");
      chk(d, st(1, 0, 1, 0), "read data moved while frozen");
      ce = 1'b1;
      fef = 1'b0;
      lg = 1'b1;
      rd_chk(5'h01, st(1, 0, 1, 0));
      $display("test freeze done");
   endtask

   task automatic t_rst2();
      fef = 1'b1;
      @(negedge clk);
      fef = 1'b0;
      nrst = 1'b0;
      @(negedge clk);
      chk(rdata, 16'h0000, "read data in reset");
      chk({15'h0000, pre}, 16'h0001, "preamble in reset");
      nrst = 1'b1;
      @(negedge clk);
      rd_chk(5'h01, st(1, 0, 0, 0));
      $display("test second reset done");
   endtask

   initial begin
      repeat (12) @(negedge clk);
      nrst = 1'b1;
      @(negedge clk);
      t_reset();
      t_link();
      t_faults();
      t_ident();
      t_freeze();
      t_rst2();
      finish_test();
   end
endmodule
